// ===== rtl/aao_pkg.sv
// Purpose: shared constants and types for the add/and execution datapath
// Assumes: 14-bit instruction words, 8-bit data, four-phase instruction cycle
// Notes:   register map for the APB slave lives here too
package aao_pkg;

  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;
  localparam int FADDR_W = 7;

  // opcode fields
  localparam logic [1:0] OP_CLASS_LIT  = 2'h3;
  localparam logic [1:0] OP_CLASS_REG  = 2'h0;
  localparam logic [2:0] OP_ADD_LIT    = 3'h7;   // 111x
  localparam logic [3:0] OP_AND_LIT    = 4'h9;
  localparam logic [3:0] OP_ADD_REG    = 4'h7;
  localparam logic [3:0] OP_AND_REG    = 4'h5;
  localparam int         DEST_BIT      = 7;
  localparam int         DIGIT_BIT     = 4;

  // instruction field positions
  localparam int         CLASS_HI      = 13;
  localparam int         CLASS_LO      = 12;
  localparam int         OPC_HI        = 11;
  localparam int         OPC_LO        = 8;
  localparam int         OPC_LIT_LO    = 9;   // add literal ignores bit 8

  // apb register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_INSTR  = 8'h04;
  localparam logic [7:0] ADDR_ACCUM  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_FADDR  = 8'h10;
  localparam logic [7:0] ADDR_FDATA  = 8'h14;

  localparam int CTRL_GO_BIT   = 0;
  localparam int STAT_NULL_BIT = 0;
  localparam int STAT_DC_BIT   = 1;
  localparam int STAT_OVF_BIT  = 2;
  localparam int STAT_BUSY_BIT = 3;

  localparam logic [7:0]  ACCUM_RST = 8'h00;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b010,
    PH_Q3   = 3'b011,
    PH_Q4   = 3'b100
  } aao_phase_type;

  typedef enum logic [2:0] {
    OPS_NONE    = 3'b000,
    OPS_ADD_LIT = 3'b001,
    OPS_AND_LIT = 3'b010,
    OPS_ADD_REG = 3'b011,
    OPS_AND_REG = 3'b100
  } aao_op_type;

endpackage : aao_pkg

// ===== rtl/aao_file_if.sv
// Purpose: file-register port between sequencer and register file
// Assumes: single clock, one write port, one read port
// Notes:   read is combinational from the addressed entry
`timescale 1ns/100ps
`default_nettype none
interface aao_file_if;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  logic       wrEn;
  logic [6:0] wrAddr;
  logic [7:0] wrData;
  modport master (output rdAddr, output wrEn, output wrAddr, output wrData, input rdData);
  modport slave  (input rdAddr, input wrEn, input wrAddr, input wrData, output rdData);
endinterface : aao_file_if
`default_nettype wire

// ===== rtl/aao_file_regs.sv
// Purpose: file registers addressed 0 to 127
// Assumes: flip-flop storage, one write per clock
// Notes:   contents reset to zero
`timescale 1ns/100ps
`default_nettype none
module aao_file_regs #(
  parameter int DEPTH = 128
) (
  input  wire logic clk,
  input  wire logic rst_b,
  aao_file_if.slave fp
);
  import aao_pkg::*;

  logic [DATA_W-1:0] mem_reg  [DEPTH];
  logic [DATA_W-1:0] mem_next [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (fp.wrEn) begin
      mem_next[fp.wrAddr] = fp.wrData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= ACCUM_RST;
      end
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign fp.rdData = mem_reg[fp.rdAddr];

endmodule : aao_file_regs
`default_nettype wire

// ===== rtl/aao_core.sv
// Purpose: execution datapath for add/and with literal and with file register
// Assumes: software loads an instruction word over APB and starts it
// Notes:   one instruction runs through four phases, one clock each
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - add literal 11 111x: accum gets accum plus literal, update all three flags
// - and literal 11 1001: accum gets accum and literal, only null flag changes
// - add register 00 0111 d f: accum plus file register, update all flags
// - and register 00 0101 d f: accum and file register, only null flag
// - destination bit 0 writes accum, 1 writes the file register back
// - literal is unsigned eight bits from the low byte of the word
// - register forms: decode Q1, read Q2, process Q3, write Q4
// - literal forms: decode Q1, read literal Q2, process Q3, write accum Q4
module aao_core (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  accumOut,
  output logic             busyOut
);
  import aao_pkg::*;

  aao_file_if fp ();

  aao_file_regs #(
    .DEPTH (128)
  ) u_file (
    .clk   (clk),
    .rst_b (rst_b),
    .fp    (fp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  aao_phase_type        phase_reg,   phase_next;
  aao_op_type           op_reg,      op_next;
  logic [INSTR_W-1:0]   instr_reg,   instr_next;
  logic [DATA_W-1:0]    accum_reg,   accum_next;
  logic [DATA_W-1:0]    operand_reg, operand_next;
  logic [DATA_W-1:0]    result_reg,  result_next;
  logic                 dest_reg,    dest_next;
  logic                 nullF_reg,   nullF_next;
  logic                 dcF_reg,     dcF_next;
  logic                 ovfF_reg,    ovfF_next;
  logic                 nullR_reg,   nullR_next;
  logic                 dcR_reg,     dcR_next;
  logic                 ovfR_reg,    ovfR_next;
  logic [FADDR_W-1:0]   faddr_reg,   faddr_next;
  logic [31:0]          prdata_reg,  prdata_next;
  logic                 pready_reg,  pready_next;
  logic                 pslverr_reg, pslverr_next;
  logic [CLASS_HI-CLASS_LO:0] instrClass;
  logic [OPC_HI-OPC_LO:0]     instrOpc;
  logic                 opIsAdd;
  logic                 opIsLit;
  logic                 opIsReg;
  logic                 addrMapped;
  logic [31:0]          instrWord;
  logic [31:0]          accumWord;
  logic [31:0]          faddrWord;
  logic [31:0]          fileWord;

  logic [DATA_W:0]      sumFull;
  logic [DIGIT_BIT:0]   sumLow;
  logic [DATA_W-1:0]    andVal;
  logic                 apbSetup;
  logic                 apbWr;
  logic                 apbRd;

  assign sumFull  = {1'b0, accum_reg} + {1'b0, operand_reg};
  assign sumLow   = {1'b0, accum_reg[DIGIT_BIT-1:0]} + {1'b0, operand_reg[DIGIT_BIT-1:0]};
  assign andVal   = accum_reg & operand_reg;
  // answer in the first access cycle: pready registered in setup
  assign apbSetup = psel && !penable;
  assign apbWr    = psel && penable && pready_reg && pwrite;
  assign apbRd    = apbSetup && !pwrite;

  // instruction fields, taken from the word held since the go write
  assign instrClass = instr_reg[CLASS_HI:CLASS_LO];
  assign instrOpc   = instr_reg[OPC_HI:OPC_LO];
  assign opIsAdd    = (op_reg == OPS_ADD_LIT) || (op_reg == OPS_ADD_REG);
  assign opIsLit    = (op_reg == OPS_ADD_LIT) || (op_reg == OPS_AND_LIT);
  assign opIsReg    = (op_reg == OPS_ADD_REG) || (op_reg == OPS_AND_REG);

  // decode of the register map, used only by the write path; the read path decodes paddr on its own
  assign addrMapped = (paddr == ADDR_CTRL) || (paddr == ADDR_INSTR) || (paddr == ADDR_ACCUM)
                      || (paddr == ADDR_STATUS) || (paddr == ADDR_FADDR) || (paddr == ADDR_FDATA);

  // read words: data in the low bits, the rest zero
  assign instrWord  = 32'(instr_reg);
  assign accumWord  = 32'(accum_reg);
  assign faddrWord  = 32'(faddr_reg);
  assign fileWord   = 32'(fp.rdData);

  assign fp.rdAddr = faddr_reg;
  assign fp.wrAddr = faddr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and datapath
  always_comb begin
    phase_next   = phase_reg;
    op_next      = op_reg;
    instr_next   = instr_reg;
    accum_next   = accum_reg;
    operand_next = operand_reg;
    result_next  = result_reg;
    dest_next    = dest_reg;
    nullF_next   = nullF_reg;
    dcF_next     = dcF_reg;
    ovfF_next    = ovfF_reg;
    nullR_next   = nullR_reg;
    dcR_next     = dcR_reg;
    ovfR_next    = ovfR_reg;
    faddr_next   = faddr_reg;
    fp.wrEn      = 1'b0;
    fp.wrData    = result_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (apbWr && paddr == ADDR_CTRL && pwdata[CTRL_GO_BIT]) begin
          phase_next = PH_Q1;
        end
      end
      PH_Q1: begin
        op_next    = OPS_NONE;
        faddr_next = instr_reg[FADDR_W-1:0];
        dest_next  = instr_reg[DEST_BIT];
        if (instrClass == OP_CLASS_LIT) begin
          if (instr_reg[OPC_HI:OPC_LIT_LO] == OP_ADD_LIT) begin
            op_next = OPS_ADD_LIT;
          end else if (instrOpc == OP_AND_LIT) begin
            op_next = OPS_AND_LIT;
          end
        end else if (instrClass == OP_CLASS_REG) begin
          if (instrOpc == OP_ADD_REG) begin
            op_next = OPS_ADD_REG;
          end else if (instrOpc == OP_AND_REG) begin
            op_next = OPS_AND_REG;
          end
        end
        phase_next = PH_Q2;
      end
      PH_Q2: begin
        if (opIsLit) begin
          operand_next = instr_reg[DATA_W-1:0];
        end else begin
          // file address was latched in Q1, so the entry is readable here
          operand_next = fp.rdData;
        end
        phase_next = PH_Q3;
      end
      PH_Q3: begin
        result_next = opIsAdd ? sumFull[DATA_W-1:0] : andVal;
        nullR_next  = (result_next == ACCUM_RST);
        dcR_next    = sumLow[DIGIT_BIT];
        ovfR_next   = sumFull[DATA_W];
        phase_next  = PH_Q4;
      end
      PH_Q4: begin
        // flags updated here are results of this instruction, not sticky
        case (op_reg)
          OPS_ADD_LIT, OPS_ADD_REG: begin
            nullF_next = nullR_reg;
            dcF_next   = dcR_reg;
            ovfF_next  = ovfR_reg;
          end
          OPS_AND_LIT, OPS_AND_REG: begin
            nullF_next = nullR_reg;
          end
          default: begin
          end
        endcase
        if (opIsReg) begin
          if (dest_reg) begin
            fp.wrEn = 1'b1;
          end else begin
            accum_next = result_reg;
          end
        end else if (op_reg != OPS_NONE) begin
          accum_next = result_reg;
        end
        phase_next = PH_IDLE;
      end
      default: begin
        phase_next = PH_IDLE;
      end
    endcase
    // writes to mapped addresses while busy are dropped without an error response
    if (phase_reg == PH_IDLE && apbWr) begin
      if (paddr == ADDR_INSTR) begin
        instr_next = pwdata[INSTR_W-1:0];
      end else if (paddr == ADDR_ACCUM) begin
        accum_next = pwdata[DATA_W-1:0];
      end else if (paddr == ADDR_FADDR) begin
        faddr_next = pwdata[FADDR_W-1:0];
      end
      // file data writes are accepted, only instructions store into the file
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: pready high in every access cycle, zero wait states
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = apbSetup;
    pslverr_next = 1'b0;
    if (apbRd) begin
      if (paddr == ADDR_CTRL) begin
        prdata_next = ZERO_WORD;
      end else if (paddr == ADDR_INSTR) begin
        prdata_next = instrWord;
      end else if (paddr == ADDR_ACCUM) begin
        prdata_next = accumWord;
      end else if (paddr == ADDR_STATUS) begin
        prdata_next = ZERO_WORD;
        prdata_next[STAT_NULL_BIT] = nullF_reg;
        prdata_next[STAT_DC_BIT]   = dcF_reg;
        prdata_next[STAT_OVF_BIT]  = ovfF_reg;
        prdata_next[STAT_BUSY_BIT] = (phase_reg != PH_IDLE);
      end else if (paddr == ADDR_FADDR) begin
        prdata_next = faddrWord;
      end else if (paddr == ADDR_FDATA) begin
        prdata_next = fileWord;
      end else begin
        prdata_next  = ZERO_WORD;
        pslverr_next = 1'b1;
      end
    end else if (apbSetup && pwrite) begin
      // unmapped writes are refused and return a zero word
      if (!addrMapped) begin
        prdata_next  = ZERO_WORD;
        pslverr_next = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg   <= PH_IDLE;
      op_reg      <= OPS_NONE;
      instr_reg   <= '0;
      accum_reg   <= ACCUM_RST;
      operand_reg <= '0;
      result_reg  <= '0;
      dest_reg    <= 1'b0;
      nullF_reg   <= 1'b0;
      dcF_reg     <= 1'b0;
      ovfF_reg    <= 1'b0;
      nullR_reg   <= 1'b0;
      dcR_reg     <= 1'b0;
      ovfR_reg    <= 1'b0;
      faddr_reg   <= '0;
      prdata_reg  <= ZERO_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      accumOut    <= ACCUM_RST;
      busyOut     <= 1'b0;
    end else begin
      phase_reg   <= phase_next;
      op_reg      <= op_next;
      instr_reg   <= instr_next;
      accum_reg   <= accum_next;
      operand_reg <= operand_next;
      result_reg  <= result_next;
      dest_reg    <= dest_next;
      nullF_reg   <= nullF_next;
      dcF_reg     <= dcF_next;
      ovfF_reg    <= ovfF_next;
      nullR_reg   <= nullR_next;
      dcR_reg     <= dcR_next;
      ovfR_reg    <= ovfR_next;
      faddr_reg   <= faddr_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      accumOut    <= accum_next;
      busyOut     <= (phase_next != PH_IDLE);
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : aao_core
`default_nettype wire

// ===== tb/aao_core_chk.sv
// Purpose: port checker for aao_core
// Assumes: zero-wait APB slave, four-phase run
// Notes:   bound to every aao_core instance
`timescale 1ns/100ps
`default_nettype none
module aao_core_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  accumOut,
  input wire logic        busyOut
);
  import aao_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic accWr;
  logic goWr;
  logic setup;
  assign setup = psel && !penable;
  assign accWr = psel && penable && pwrite && paddr == ADDR_ACCUM;
  assign goWr  = psel && penable && pready && pwrite && paddr == ADDR_CTRL
                 && pwdata[CTRL_GO_BIT] && !busyOut;
  ////////////////////////////////////////
  AST_GO_RUN: assert property (goWr |=> busyOut [*4] ##1 !busyOut)
    else $error("run length wrong");
  AST_HOLD_Q: assert property ($rose(busyOut) |-> $stable(accumOut) [*4])
    else $error("accum moved before Q4");
  AST_IDLE: assert property (!busyOut && !accWr |=> $stable(accumOut))
    else $error("accum changed while idle");
  AST_ACC_WR: assert property (accWr && pready && !busyOut
    |=> {24'h00_0000, accumOut} == ($past(pwdata) & 32'h0000_00FF))
    else $error("accum write lost");
  AST_READY: assert property (setup |=> pready)
    else $error("no ready after setup");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_ERR: assert property (setup && paddr > ADDR_FDATA |=> pslverr && prdata == ZERO_WORD)
    else $error("unmapped not flagged");
  AST_OK: assert property (setup && paddr <= ADDR_FDATA && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped flagged");
  AST_BUSY_RD: assert property (setup && !pwrite && paddr == ADDR_STATUS
    |=> prdata[STAT_BUSY_BIT] == $past(busyOut))
    else $error("busy bit wrong");
endmodule : aao_core_chk
bind aao_core aao_core_chk chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .accumOut(accumOut), .busyOut(busyOut));
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench for aao_core
// Assumes: zero-wait APB slave, file registers reset to zero
// Notes:   status word holds null, digit carry, carry in bits 0..2
`timescale 1ns/100ps
`default_nettype none
module tb;
  import aao_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, busyOut, errv;
  logic [7:0]  paddr, accumOut;
  logic [31:0] pwdata, prdata, rdv;
  int          errorCnt, nCompared;
  aao_core uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accumOut(accumOut), .busyOut(busyOut));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////
  task summarize;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", s, e, g);
      errorCnt++;
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // ready, read data and error are taken at the edge that completes the access
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errorCnt++;
      summarize();
    end
  endtask : apb
  task idle;
    int i;
    for (i = 0; i < 20; i++) begin
      apb(1'b0, ADDR_STATUS, ZERO_WORD);
      if (rdv[STAT_BUSY_BIT] === 1'b0) break;
    end
    if (i == 20) begin
      errorCnt++;
      summarize();
    end
  endtask : idle
  task op(input logic [13:0] i, input logic [7:0] a, input logic [7:0] ea, input logic [31:0] es);
    apb(1'b1, ADDR_ACCUM, {24'h00_0000, a});
    apb(1'b1, ADDR_INSTR, {18'h0_0000, i});
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    idle();
    apb(1'b0, ADDR_ACCUM, ZERO_WORD);
    chk("accum", {24'h00_0000, ea}, rdv);
    chk("accumOut", {24'h00_0000, ea}, {24'h00_0000, accumOut});
    apb(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("status", es, rdv);
  endtask : op
  ////////////////////////////////////////
  task t_lit;
    op(14'h3E15, 8'h10, 8'h25, 32'h0000_0000);
    op(14'h3FFF, 8'h01, 8'h00, 32'h0000_0007);
    op(14'h395F, 8'hA3, 8'h03, 32'h0000_0006);
    $display("test literal done");
  endtask : t_lit
  task t_reg;
    op(14'h07FF, 8'h17, 8'h17, 32'h0000_0000);
    op(14'h07FF, 8'hAB, 8'hAB, 32'h0000_0002);
    apb(1'b0, ADDR_FDATA, ZERO_WORD);
    chk("file", 32'h0000_00C2, rdv);
    op(14'h077F, 8'h17, 8'hD9, 32'h0000_0000);
    op(14'h05FF, 8'h17, 8'h17, 32'h0000_0000);
    apb(1'b0, ADDR_FDATA, ZERO_WORD);
    chk("file", 32'h0000_0002, rdv);
    op(14'h057F, 8'h01, 8'h00, 32'h0000_0001);
    $display("test register done");
  endtask : t_reg
  task t_err;
    apb(1'b1, ADDR_ACCUM, 32'h0000_00FF);
    apb(1'b1, ADDR_INSTR, 32'h0000_390F);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, ADDR_ACCUM, 32'h0000_0055);
    idle();
    apb(1'b0, ADDR_ACCUM, ZERO_WORD);
    chk("accum", 32'h0000_000F, rdv);
    apb(1'b0, 8'h20, ZERO_WORD);
    chk("slverr", 32'h0000_0001, {31'h0, errv});
    chk("rdata", ZERO_WORD, rdv);
    // undecoded opcode: the phases run and nothing changes
    op(14'h3A0F, 8'h5A, 8'h5A, ZERO_WORD);
    $display("test refusal done");
  endtask : t_err
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = ZERO_WORD;
    errorCnt = 0;
    nCompared = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, ADDR_STATUS, ZERO_WORD);
    chk("status", ZERO_WORD, rdv);
    t_lit();
    t_reg();
    t_err();
    summarize();
  end
endmodule : tb
`default_nettype wire
